// file: rtl/fsw_out_fifo.sv
// Module: synchronous FIFO with valid/ready on both sides for output samples
`timescale 1ns/10ps
`default_nettype none
module fsw_out_fifo
   import fsw_pkg::*;
#(
   parameter int W     = 24,
   parameter int CW    = 8,
   parameter int DEPTH = FIFO_DEPTH_DEF
)(
   // Clock, enable, reset
   input  wire logic clk_in,
   input  wire logic ce_in,
   input  wire logic rst_in,
   // Fill and drain sides
   fsw_stream_if.snk wr,
   fsw_stream_if.src rd
);
   localparam int AW = $clog2(DEPTH);
   typedef struct packed {
      logic [AW-1:0] wp;
      logic [AW-1:0] rp;
      logic [AW:0]   cnt;
   } fifo_t;
   fifo_t st_reg, st_next;
   logic [W+CW-1:0] mem [DEPTH];
   logic push, pop;
   // ------------------------------------------------------------
   // Handshake terms
   // ------------------------------------------------------------
   assign wr.ready = (st_reg.cnt != (AW+1)'(DEPTH));   // Honest full
   assign rd.valid = (st_reg.cnt != '0);               // Honest empty
   assign {rd.idx, rd.data} = mem[st_reg.rp];
   assign push = ce_in && wr.valid && wr.ready;
   assign pop  = ce_in && rd.valid && rd.ready;
   // Pointer update
   always_comb begin
      st_next = st_reg;
      if (push) st_next.wp = (st_reg.wp == AW'(DEPTH-1)) ? '0 : st_reg.wp + 1'b1;
      if (pop)  st_next.rp = (st_reg.rp == AW'(DEPTH-1)) ? '0 : st_reg.rp + 1'b1;
      st_next.cnt = st_reg.cnt + (AW+1)'(push) - (AW+1)'(pop);
   end
   always_ff @(posedge clk_in) begin
      if (rst_in) st_reg <= '0;
      else if (ce_in) st_reg <= st_next;
   end
   // Storage array has no reset; only written cells are ever read
   always_ff @(posedge clk_in) begin
      if (push) mem[st_reg.wp] <= {wr.idx, wr.data};
   end
   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   // A result that meets a full FIFO would be lost, so depth must cover the pipe
   a_fifo_no_overflow: assert property (@(posedge clk_in) disable iff (rst_in)
      ce_in && wr.valid |-> wr.ready) else $error("fifo full drops a result");
   a_fifo_count_step: assert property (@(posedge clk_in) disable iff (rst_in)
      ce_in && push && !pop |=> st_reg.cnt == $past(st_reg.cnt) + 1'b1)
      else $error("fifo count did not rise on push");
endmodule : fsw_out_fifo
`default_nettype wire

// file: rtl/fsw_pkg.sv
// Package: constants shared by the filter stream wrapper files
package fsw_pkg;
   // ------------------------------------------------------------
   // Stream shape defaults
   // ------------------------------------------------------------
   localparam int DATA_W_DEF     = 8;   // Symbol width per lane
   localparam int LANES_DEF      = 3;   // Channel wires per beat
   localparam int TDM_DEF        = 2;   // Channels per wire
   localparam int PIPE_DEPTH_DEF = 4;   // Filter pipeline latency in cycles
   localparam int FIFO_DEPTH_DEF = 8;   // Output FIFO entries, more than pipe depth
   localparam int BUF_DEPTH      = 2;   // Skid buffer entries
   localparam int CNT_W          = 8;   // Packet index width
   // ------------------------------------------------------------
   // Reset values
   // ------------------------------------------------------------
   localparam logic [CNT_W-1:0] PKT_IDX_FIRST = 8'h01; // Packet index starts at one
   localparam logic             RST_LOW       = 1'b0;
endpackage : fsw_pkg

// file: rtl/fsw_stream_if.sv
// Interface: valid/ready stream carrying data and packet position between modules
`timescale 1ns/10ps
`default_nettype none
interface fsw_stream_if #(parameter int W = 24, parameter int CW = 8);
   logic          valid;
   logic          ready;
   logic [W-1:0]  data;
   logic [CW-1:0] idx;
   modport src (output valid, output data, output idx, input ready);
   modport snk (input valid, input data, input idx, output ready);
endinterface : fsw_stream_if
`default_nettype wire

// file: rtl/fsw_wrapper.sv
// Module: streaming wrapper with flow control, output FIFO and packet markers
`timescale 1ns/10ps
`default_nettype none
// Behaviour
// - Transfers happen when valid and ready are both high, zero ready latency.
// - Each beat carries one symbol per lane of configured data width.
// - Symbols are signed or unsigned by configuration.
// - Supports one channel, TDM channels, and channels over several lanes.
// - Six channels at 200/100 MHz give TDM 2, three lanes.
// - All handshakes pass through one central controller.
// - Output FIFO exists only when backpressure support is on.
// - FIFO catches samples the filter emits after backpressure begins.
// - Dropping advance enable freezes the filter datapath.
// - Downstream backpressure drops the advance enable.
// - Advance enable returns at once when downstream can accept.
// - Start marker rises with valid when packet index is 1.
// - End marker rises with valid when index equals packet size.
// - Source stall raised whenever downstream is not ready.
// - Input ready shows acceptance; absent without backpressure support.
// - One system clock; reset initialises the control circuit.
module fsw_wrapper
   import fsw_pkg::*;
#(
   parameter int DATA_W     = DATA_W_DEF,
   parameter int LANES      = LANES_DEF,
   parameter int TDM        = TDM_DEF,
   parameter int PIPE_DEPTH = PIPE_DEPTH_DEF,
   parameter int FIFO_DEPTH = FIFO_DEPTH_DEF,
   parameter bit BACKPRESS  = 1'b1,
   parameter bit SIGNED_SYM = 1'b1
)(
   // Clock, enable, reset
   input  wire logic                    CLK_IN,
   input  wire logic                    CE_IN,
   input  wire logic                    SYS_RST_IN,
   // Sink side
   input  wire logic                    SINK_VALID_IN,
   input  wire logic [DATA_W*LANES-1:0] SINK_DATA_IN,
   output var  logic                    SINK_READY_OUT,
   // Filter datapath side
   output var  logic                    FILTER_ADV_EN_OUT,
   output var  logic                    FILTER_IN_STROBE_OUT,
   output var  logic [DATA_W*LANES-1:0] FILTER_IN_DATA_OUT,
   input  wire logic                    FILTER_OUT_STROBE_IN,
   input  wire logic [DATA_W*LANES-1:0] FILTER_OUT_DATA_IN,
   input  wire logic [CNT_W-1:0]        FILTER_OUT_LANE_TAG_IN,
   // Packet configuration
   input  wire logic [CNT_W-1:0]        PKT_SIZE_IN,
   // Source side
   input  wire logic                    SOURCE_READY_IN,
   output var  logic                    SOURCE_VALID_OUT,
   output var  logic [DATA_W*LANES-1:0] SOURCE_DATA_OUT,
   output var  logic                    SOURCE_SOP_OUT,
   output var  logic                    SOURCE_EOP_OUT,
   output var  logic [CNT_W-1:0]        SOURCE_CHANNEL_OUT,
   output var  logic                    SOURCE_STALL_OUT,
   output var  logic [LANES-1:0]        SOURCE_NEG_OUT
);
   localparam int DW = DATA_W*LANES;
   // ------------------------------------------------------------
   // State
   // ------------------------------------------------------------
   typedef struct packed {
      logic          sink_rdy;
      logic          adv_en;
      logic          in_stb;
      logic [DW-1:0] in_data;
      logic          src_vld;
      logic [DW-1:0] src_data;
      logic          sop;
      logic          eop;
      logic [CNT_W-1:0] chan;
      logic          stall;
      logic [LANES-1:0] neg;
      logic [$clog2(PIPE_DEPTH+1)-1:0] infl;
   } wrap_t;
   wrap_t st_reg, st_next;
   // Sign bit of one lane; unsigned mode never reports a negative symbol
   function automatic logic lane_neg(input logic [DW-1:0] d, input int k);
      lane_neg = SIGNED_SYM && d[k*DATA_W + DATA_W-1];
   endfunction : lane_neg
   // ------------------------------------------------------------
   // Output path: FIFO when backpressure is on, else direct
   // ------------------------------------------------------------
   fsw_stream_if #(.W(DW), .CW(CNT_W)) f_wr ();
   fsw_stream_if #(.W(DW), .CW(CNT_W)) f_rd ();
   assign f_wr.valid = FILTER_OUT_STROBE_IN;
   assign f_wr.data  = FILTER_OUT_DATA_IN;
   assign f_wr.idx   = FILTER_OUT_LANE_TAG_IN;
   // Output register accepts when empty or being drained
   assign f_rd.ready = !st_reg.src_vld || SOURCE_READY_IN;
   generate
      if (BACKPRESS) begin : g_fifo
         fsw_out_fifo #(.W(DW), .CW(CNT_W), .DEPTH(FIFO_DEPTH)) u_fifo (
            .clk_in (CLK_IN),
            .ce_in  (CE_IN),
            .rst_in (SYS_RST_IN),
            .wr     (f_wr),
            .rd     (f_rd)
         );
      end else begin : g_direct
         assign f_rd.valid = f_wr.valid;
         assign f_rd.data  = f_wr.data;
         assign f_rd.idx   = f_wr.idx;
         assign f_wr.ready = 1'b1;
      end
   endgenerate
   // ------------------------------------------------------------
   // Central controller: advance enable, input ready, stall
   // ------------------------------------------------------------
   logic fifo_room, take_in, take_out, ready_next;
   // Room is a fixed parameter check that FIFO depth exceeds pipe depth; samples in the pipe are not counted
   assign fifo_room = (FIFO_DEPTH - PIPE_DEPTH - 1) >= 0;
   // Without backpressure there is no ready, so every valid beat is taken
   assign take_in  = SINK_VALID_IN && (st_reg.sink_rdy || !BACKPRESS);
   assign take_out = f_rd.valid && f_rd.ready;
   assign ready_next = BACKPRESS ? SOURCE_READY_IN : 1'b1;
   always_comb begin
      st_next = st_reg;
      // Controller routes every handshake
      st_next.stall    = !SOURCE_READY_IN;
      st_next.adv_en   = ready_next && fifo_room;
      st_next.sink_rdy = BACKPRESS ? ready_next : 1'b0;
      // Input beats go to the filter only when valid; gaps send no strobe, the filter keeps advancing
      st_next.in_stb   = take_in;
      if (take_in) st_next.in_data = SINK_DATA_IN;
      // Source output register
      if (take_out) begin
         st_next.src_vld  = 1'b1;
         st_next.src_data = f_rd.data;
         st_next.chan     = f_rd.idx;
         st_next.sop      = (f_rd.idx == PKT_IDX_FIRST);
         st_next.eop      = (f_rd.idx == PKT_SIZE_IN);
         for (int k = 0; k < LANES; k++) begin
            st_next.neg[k] = lane_neg(f_rd.data, k);
         end
      end else if (SOURCE_READY_IN) begin
         st_next.src_vld = 1'b0;
         st_next.sop     = 1'b0;
         st_next.eop     = 1'b0;
      end
      // Track beats in the pipe for the in-flight view
      if (take_in && !FILTER_OUT_STROBE_IN && st_reg.infl != '1)
         st_next.infl = st_reg.infl + 1'b1;
      else if (!take_in && FILTER_OUT_STROBE_IN && st_reg.infl != '0)
         st_next.infl = st_reg.infl - 1'b1;
   end
   // ------------------------------------------------------------
   // State register; clock enable freezes everything
   // ------------------------------------------------------------
   always_ff @(posedge CLK_IN) begin
      if (SYS_RST_IN) begin
         st_reg          <= '0;
         st_reg.adv_en   <= RST_LOW;
      end else if (CE_IN) begin
         st_reg <= st_next;
      end
   end
   // ------------------------------------------------------------
   // Outputs straight from flops
   // ------------------------------------------------------------
   assign SINK_READY_OUT       = st_reg.sink_rdy;
   assign FILTER_ADV_EN_OUT    = st_reg.adv_en;
   assign FILTER_IN_STROBE_OUT = st_reg.in_stb;
   assign FILTER_IN_DATA_OUT   = st_reg.in_data;
   assign SOURCE_VALID_OUT     = st_reg.src_vld;
   assign SOURCE_DATA_OUT      = st_reg.src_data;
   assign SOURCE_SOP_OUT       = st_reg.sop;
   assign SOURCE_EOP_OUT       = st_reg.eop;
   assign SOURCE_CHANNEL_OUT   = st_reg.chan;
   assign SOURCE_STALL_OUT     = st_reg.stall;
   assign SOURCE_NEG_OUT       = st_reg.neg;
   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   default clocking cb @(posedge CLK_IN); endclocking
   default disable iff (SYS_RST_IN);
   a_stall_follows_ready: assert property (
      CE_IN |=> SOURCE_STALL_OUT == !$past(SOURCE_READY_IN))
      else $error("stall does not track downstream ready");
   a_adv_drop_bp: assert property (
      BACKPRESS && CE_IN && !SOURCE_READY_IN |=> !FILTER_ADV_EN_OUT)
      else $error("advance enable kept during backpressure");
   a_adv_resume: assert property (
      BACKPRESS && CE_IN && SOURCE_READY_IN && fifo_room |=> FILTER_ADV_EN_OUT)
      else $error("advance enable not restored at once");
   a_sop_index_one: assert property (
      CE_IN && take_out && f_rd.idx == PKT_IDX_FIRST |=> SOURCE_SOP_OUT && SOURCE_VALID_OUT)
      else $error("start marker missing");
   a_eop_index_last: assert property (
      CE_IN && take_out && f_rd.idx == PKT_SIZE_IN |=> SOURCE_EOP_OUT && SOURCE_VALID_OUT)
      else $error("end marker missing");
   a_sop_needs_valid: assert property (SOURCE_SOP_OUT |-> SOURCE_VALID_OUT)
      else $error("start marker without valid");
   a_source_hold: assert property (
      SOURCE_VALID_OUT && !SOURCE_READY_IN |=> SOURCE_VALID_OUT && $stable(SOURCE_DATA_OUT))
      else $error("output lost under stall");
   a_in_strobe_cause: assert property (
      CE_IN |=> FILTER_IN_STROBE_OUT == $past(SINK_VALID_IN && (SINK_READY_OUT || !BACKPRESS)))
      else $error("input strobe without transfer");
   a_ready_absent: assert property (!BACKPRESS |-> !SINK_READY_OUT)
      else $error("input ready driven without backpressure");
   c_packet_start: cover property (SOURCE_VALID_OUT && SOURCE_SOP_OUT && SOURCE_READY_IN);
   c_packet_end:   cover property (SOURCE_VALID_OUT && SOURCE_EOP_OUT && SOURCE_READY_IN);
   c_stall_resume: cover property (SOURCE_STALL_OUT ##1 !SOURCE_STALL_OUT);
   c_in_gap:       cover property (take_in ##1 !SINK_VALID_IN ##1 take_in);
   c_pipe_full:    cover property (st_reg.infl == PIPE_DEPTH);
endmodule : fsw_wrapper
`default_nettype wire

// file: test/fsw_filter_model.sv
// Behavioural filter datapath: delays each sample by a count of enabled cycles
`timescale 1ns/10ps
`default_nettype none
module fsw_filter_model
   import fsw_pkg::*;
#(
   parameter int W     = 24,
   parameter int DEPTH = PIPE_DEPTH_DEF
)(
   // Clock and reset
   input  wire logic             clk_in,
   input  wire logic             rst_in,
   // Wrapper side
   input  wire logic             adv_en_in,
   input  wire logic             strobe_in,
   input  wire logic [W-1:0]     data_in,
   input  wire logic [CNT_W-1:0] pkt_size_in,
   output var  logic             strobe_out,
   output var  logic [W-1:0]     data_out,
   output var  logic [CNT_W-1:0] tag_out
);
   logic [W-1:0] q_data[$];
   int           q_left[$];
   int           idx;
   // Samples age only on enabled cycles; idle result data toggles, the tag holds
   always @(posedge clk_in) begin
      strobe_out <= 1'b0;
      data_out   <= ~data_out;
      if (rst_in) begin
         q_data.delete();
         q_left.delete();
         data_out <= '0;
         tag_out  <= '0;
         idx = 1;
      end else begin
         if (adv_en_in) begin
            foreach (q_left[i])
               q_left[i]--;
            if (q_left.size() > 0 && q_left[0] <= 0) begin
               strobe_out <= 1'b1;
               data_out   <= q_data.pop_front();
               tag_out    <= CNT_W'(idx);
               void'(q_left.pop_front());
               idx = (idx == int'(pkt_size_in)) ? 1 : idx + 1;
            end
         end
         // A late strobe while frozen is still captured
         if (strobe_in) begin
            q_data.push_back(data_in);
            q_left.push_back(DEPTH);
         end
      end
   end
endmodule : fsw_filter_model
`default_nettype wire

// file: test/test_fsw_wrapper.sv
// Testbench: stream, backpressure and packet marker scenarios for the wrapper
`timescale 1ns/10ps
`default_nettype none
module test_fsw_wrapper
   import fsw_pkg::*;
;
   localparam int DW = DATA_W_DEF*LANES_DEF;
   logic clk = 1'b0, rst = 1'b1, s_valid = 1'b0, s_ready, adv, f_in_stb, f_stb;
   logic src_ready = 1'b1, src_valid, sop, eop, stall;
   logic [DW-1:0] s_data = '0, f_in_data, f_data, src_data;
   logic [CNT_W-1:0] f_tag, chan, pkt = 8'h03;
   logic [LANES_DEF-1:0] neg;
   logic [DW-1:0] exp_q[$];
   int n_fail = 0, total_checks = 0, n_sent = 0, n_got = 0, exp_idx = 1;
   // Second wrapper: no backpressure, unsigned symbols, filter side driven here
   logic nb_ce = 1'b1, nb_svalid = 1'b0, nb_stb = 1'b0, nb_ready, nb_in_stb;
   logic nb_valid, nb_sop, nb_eop;
   logic [DW-1:0] nb_data = '0, nb_in_data, nb_out;
   logic [CNT_W-1:0] nb_tag = '0, nb_chan;
   logic [LANES_DEF-1:0] nb_neg;

   fsw_wrapper u_dut (.CLK_IN(clk), .CE_IN(1'b1), .SYS_RST_IN(rst),
      .SINK_VALID_IN(s_valid), .SINK_DATA_IN(s_data), .SINK_READY_OUT(s_ready),
      .FILTER_ADV_EN_OUT(adv), .FILTER_IN_STROBE_OUT(f_in_stb),
      .FILTER_IN_DATA_OUT(f_in_data), .FILTER_OUT_STROBE_IN(f_stb),
      .FILTER_OUT_DATA_IN(f_data), .FILTER_OUT_LANE_TAG_IN(f_tag), .PKT_SIZE_IN(pkt),
      .SOURCE_READY_IN(src_ready), .SOURCE_VALID_OUT(src_valid),
      .SOURCE_DATA_OUT(src_data), .SOURCE_SOP_OUT(sop), .SOURCE_EOP_OUT(eop),
      .SOURCE_CHANNEL_OUT(chan), .SOURCE_STALL_OUT(stall), .SOURCE_NEG_OUT(neg));
   fsw_filter_model #(.W(DW)) u_filt (.clk_in(clk), .rst_in(rst), .adv_en_in(adv),
      .strobe_in(f_in_stb), .data_in(f_in_data), .pkt_size_in(pkt),
      .strobe_out(f_stb), .data_out(f_data), .tag_out(f_tag));
   fsw_wrapper #(.BACKPRESS(1'b0), .SIGNED_SYM(1'b0)) u_dut_nb (.CLK_IN(clk), .CE_IN(nb_ce),
      .SYS_RST_IN(rst), .SINK_VALID_IN(nb_svalid), .SINK_DATA_IN(s_data),
      .SINK_READY_OUT(nb_ready), .FILTER_ADV_EN_OUT(), .FILTER_IN_STROBE_OUT(nb_in_stb),
      .FILTER_IN_DATA_OUT(nb_in_data), .FILTER_OUT_STROBE_IN(nb_stb),
      .FILTER_OUT_DATA_IN(nb_data), .FILTER_OUT_LANE_TAG_IN(nb_tag), .PKT_SIZE_IN(pkt),
      .SOURCE_READY_IN(1'b1),
      .SOURCE_VALID_OUT(nb_valid), .SOURCE_DATA_OUT(nb_out), .SOURCE_SOP_OUT(nb_sop),
      .SOURCE_EOP_OUT(nb_eop), .SOURCE_CHANNEL_OUT(nb_chan), .SOURCE_STALL_OUT(),
      .SOURCE_NEG_OUT(nb_neg));

   always #4 clk = ~clk;

   task automatic check(input string what, input logic [31:0] expv, input logic [31:0] seen);
      total_checks++;
      if (seen !== expv) begin
         n_fail++;
         $display("unexpected %s: expected %h seen %h", what, expv, seen);
      end
   endtask : check

   function automatic logic [LANES_DEF-1:0] lane_msbs(input logic [DW-1:0] d);
      for (int k = 0; k < LANES_DEF; k++)
         lane_msbs[k] = d[k*DATA_W_DEF+DATA_W_DEF-1];
   endfunction : lane_msbs

   // Score each accepted source beat; order must match accepted sink beats
   // Looked at on the falling edge, where the beat for the next rising edge has settled
   always @(negedge clk) begin
      if (!rst && src_valid === 1'b1 && src_ready) begin
         check("source data", exp_q.size() ? exp_q.pop_front() : 'x, src_data);
         check("channel", exp_idx, chan);
         check("sop", exp_idx == 1, sop);
         check("eop", exp_idx == int'(pkt), eop);
         check("sign flags", lane_msbs(src_data), neg);
         exp_idx = (exp_idx == int'(pkt)) ? 1 : exp_idx + 1;
         n_got++;
      end
   end

   // Sink driver: holds valid and data until ready is seen at an edge
   task automatic send(input int n);
      for (int i = 0; i < n; i++) begin
         s_valid = 1'b1;
         s_data  = 24'h8F1E2D + DW'(n_sent) * 24'h39A5C3;
         do @(posedge clk); while (s_ready !== 1'b1);
         exp_q.push_back(s_data);
         n_sent++;
         #1;
      end
      s_valid = 1'b0;
   endtask : send

   task automatic drain(input string name);
      for (int i = 0; i < 60 && n_got != n_sent; i++)
         @(posedge clk);
      #1;
      check("beats delivered", n_sent, n_got);
      $display("test %s done", name);
   endtask : drain

   task automatic t_reset();
      repeat (3) @(posedge clk);
      #1;
      check("valid in reset", 0, src_valid);
      check("strobe in reset", 0, f_in_stb);
      @(posedge clk);
      #1;
      rst = 1'b0;
      @(posedge clk);
      #1;
      check("sink ready", 1, s_ready);
      check("advance enable", 1, adv);
      $display("test reset done");
   endtask : t_reset

   task automatic t_stream();
      send(6);
      drain("stream");
   endtask : t_stream

   // Downstream stalls mid-stream; late results must land in the FIFO
   task automatic t_backpressure();
      fork
         send(15);
         begin
            // Stall only once results stand at the source, so valid must be held
            repeat (10) @(posedge clk);
            #1;
            src_ready = 1'b0;
            @(posedge clk);
            #1;
            check("advance enable low", 0, adv);
            check("stall", 1, stall);
            check("sink ready low", 0, s_ready);
            repeat (5) @(posedge clk);
            #1;
            check("valid held", 1, src_valid);
            src_ready = 1'b1;
            @(posedge clk);
            #1;
            check("advance enable back", 1, adv);
            check("stall released", 0, stall);
         end
      join
      drain("backpressure");
   endtask : t_backpressure

   // Packet size one: every beat is both first and last
   task automatic t_pkt_one();
      pkt = 8'h01;
      send(3);
      drain("packet size one");
   endtask : t_pkt_one

   // No backpressure, unsigned: direct path, every beat taken, clock enable freezes
   task automatic t_no_backpressure();
      nb_svalid = 1'b1;
      nb_stb    = 1'b1;
      nb_data   = 24'hF0F0F0;
      nb_tag    = 8'h01;
      @(posedge clk);
      #1;
      nb_svalid = 1'b0;
      nb_stb    = 1'b0;
      nb_ce     = 1'b0;
      check("input strobe", 1, nb_in_stb);
      check("input data", s_data, nb_in_data);
      check("input ready absent", 0, nb_ready);
      check("direct valid", 1, nb_valid);
      check("direct data", 24'hF0F0F0, nb_out);
      check("unsigned flags", 0, nb_neg);
      check("direct sop eop", 2'b11, {nb_sop, nb_eop});
      check("direct channel", 1, nb_chan);
      repeat (2) @(posedge clk);
      #1;
      check("frozen valid", 1, nb_valid);
      check("frozen strobe", 1, nb_in_stb);
      nb_ce = 1'b1;
      @(posedge clk);
      #1;
      check("direct valid drop", 0, nb_valid);
      check("input strobe drop", 0, nb_in_stb);
      $display("test no backpressure done");
   endtask : t_no_backpressure

   task automatic close_out();
      $display("checks %0d, mismatches %0d", total_checks, n_fail);
      if (n_fail == 0 && total_checks > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask : close_out

   // Watchdog: the whole run needs under a hundred cycles of the 5000 allowed
   initial begin
      #(8*5000);
      n_fail++;
      close_out();
   end

   initial begin
      t_reset();
      t_stream();
      t_backpressure();
      t_pkt_one();
      t_no_backpressure();
      close_out();
   end
endmodule : test_fsw_wrapper
`default_nettype wire
